// file: fast_adc_front_model.sv
// behavioural analog front end answering each conversion start
`timescale 1ns/1ns
`default_nettype none
module fast_adc_front_model (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // from the converter
   input wire logic conv_start_in,
   input wire logic [2:0] channel_in,
   input wire logic sample_ready_in,
   // test controls
   input wire logic [7:0] delay_in,
   input wire logic burst_in,
   // to the converter
   output logic sample_valid_out,
   output var fast_adc_pkg::sample_type sample_out
);
   logic [7:0] cnt_q;
   logic [2:0] ch_q;
   logic [5:0] n_q;
   ////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sample_valid_out <= 1'b0;
         sample_out <= '0;
         cnt_q <= 8'h00;
         ch_q <= 3'h0;
         n_q <= 6'h00;
      end else if (sample_valid_out && sample_ready_in) begin
         n_q <= n_q + 6'h01;
         sample_valid_out <= burst_in;
         // a released line must not keep the pushed word
         sample_out <= burst_in ? {3'h7, 10'h200 + {n_q + 6'h01, 3'h7}} : ~sample_out;
      end else if (conv_start_in) begin
         cnt_q <= delay_in;
         ch_q <= channel_in;
      end else if (cnt_q != 8'h00) begin
         cnt_q <= cnt_q - 8'h01;
         if (cnt_q == 8'h01) begin
            sample_valid_out <= 1'b1;
            sample_out <= {ch_q, 10'h200 + {n_q, ch_q}};
         end
      end else if (!sample_valid_out && burst_in) begin
         sample_valid_out <= 1'b1;
         sample_out <= {3'h7, 10'h200 + {n_q, 3'h7}};
      end
   end
endmodule : fast_adc_front_model
`default_nettype wire

// file: fast_adc_mode_control.sv
// control, sequencing and result registers of the fast 10-bit converter
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - control register zero on reset and standby
// - top control bit reads zero, write zero
// - fast-start bit picks start mode
// - trigger field: software only, or timer trigger
// - scan bit: single or repeated conversion
// - dual-sample bit enables two-channel sampling
// - buffer chain field selects result shifting
// - mode written with go starts using it
// - clearing go aborts; setting it restarts
// - word read returns 10-bit result, upper 6 bits zero
// - byte read returns result bits 9..2
// - each conversion stores 10 bits per channel
// - select-single holds go then clears it
// - select-single sets done flag at end
// - done flag with enable raises interrupt
// - flag clears by read-one then write-zero
// - select-scan repeats until software clears go
// - scan sets flag, halts if interrupt enabled
// - group-single converts all, clears go, sets flag
// - buffering shifts old result on new store
// - channel field picks one channel or 0..n
// - clock select gives 40 or 80 states
// - group-scan flags each pass, may halt
module fast_adc_mode_control (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic standby_in,
   // register port
   input wire logic bus_sel_in,
   input wire logic bus_wr_in,
   input wire logic bus_byte_in,
   input wire logic [3:0] bus_addr_in,
   input wire logic [15:0] bus_wdata_in,
   output logic [15:0] bus_rdata_out,
   // start trigger from the pulse timer unit
   input wire logic timer_trig_in,
   // analog front end
   output logic conv_start_out,
   output logic [2:0] conv_channel_out,
   output logic fast_start_out,
   output logic dual_sample_out,
   input wire logic sample_valid_in,
   output logic sample_ready_out,
   input wire fast_adc_pkg::sample_type sample_in,
   // interrupt
   output logic done_irq_out
);
   typedef enum {ST_IDLE, ST_CONVERT, ST_AWAIT, ST_HALTED} seq_state_type;

   seq_state_type state_q;
   logic [7:0] ccr_q;
   logic irq_en_q;
   logic go_q;
   logic cks_q;
   logic grp_q;
   logic [2:0] ch_sel_q;
   logic flag_q;
   logic arm_q;
   logic [2:0] cur_ch_q;
   logic [6:0] cnt_q;
   logic [9:0] res_q [8];
   logic init;
   logic csr_wr;
   logic ccr_wr;
   logic bus_rd;
   logic drain_ready;
   logic drain_valid;
   fast_adc_pkg::sample_type drain_data;
   logic drain_fire;
   logic last_ch;
   logic pass_end;
   logic scan;
   logic [1:0] trig_sel;
   logic [1:0] buf_sel;

   function automatic logic is_result(input logic [3:0] idx);
      is_result = (idx <= fast_adc_pkg::IDX_RESULT_H);
   endfunction : is_result

   assign init = sys_rst_in || standby_in;
   assign csr_wr = bus_sel_in && bus_wr_in && (bus_addr_in == fast_adc_pkg::IDX_CSR);
   assign ccr_wr = bus_sel_in && bus_wr_in && (bus_addr_in == fast_adc_pkg::IDX_CCR);
   assign bus_rd = bus_sel_in && !bus_wr_in;
   assign scan = ccr_q[fast_adc_pkg::CCR_SCAN_BIT];
   assign trig_sel = ccr_q[fast_adc_pkg::CCR_TRIG_HI:fast_adc_pkg::CCR_TRIG_LO];
   assign buf_sel = ccr_q[fast_adc_pkg::CCR_BUF_HI:fast_adc_pkg::CCR_BUF_LO];
   // results are not updated in a cycle the master reads one, so a read never tears
   assign drain_ready = !(bus_rd && is_result(bus_addr_in));
   assign drain_fire = drain_valid && drain_ready;
   assign last_ch = !grp_q || (cur_ch_q == ch_sel_q);
   assign pass_end = (state_q == ST_AWAIT) && drain_fire && last_ch;

   ////////////////////////////////////////////////////////////////////////////
   sample_fifo #(
      .WIDTH($bits(fast_adc_pkg::sample_type)),
      .DEPTH(fast_adc_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_in(core_clk_in),
      .rst_in(init),
      .in_valid_in(sample_valid_in),
      .in_ready_out(sample_ready_out),
      .in_data_in(sample_in),
      .out_valid_out(drain_valid),
      .out_ready_in(drain_ready),
      .out_data_out(drain_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // conversion_control
   always_ff @(posedge core_clk_in) begin
      if (init) begin
         ccr_q <= fast_adc_pkg::CCR_RESET;
      end else if (ccr_wr) begin
         // reserved bit is forced low whatever is written
         ccr_q <= {1'b0, bus_wdata_in[6:0]};
      end
   end

   assign fast_start_out = ccr_q[fast_adc_pkg::CCR_FAST_BIT];
   assign dual_sample_out = ccr_q[fast_adc_pkg::CCR_DUAL_BIT];

   // control_status_reg plain fields
   always_ff @(posedge core_clk_in) begin
      if (init) begin
         irq_en_q <= 1'b0;
         cks_q <= 1'b0;
         grp_q <= 1'b0;
         ch_sel_q <= 3'h0;
      end else if (csr_wr) begin
         irq_en_q <= bus_wdata_in[fast_adc_pkg::CSR_IRQEN_BIT];
         cks_q <= bus_wdata_in[fast_adc_pkg::CSR_CKS_BIT];
         grp_q <= bus_wdata_in[fast_adc_pkg::CSR_GRP_BIT];
         ch_sel_q <= bus_wdata_in[fast_adc_pkg::CSR_CH_HI:fast_adc_pkg::CSR_CH_LO];
      end
   end

   // go bit: a software write wins over the hardware clear of the same cycle
   always_ff @(posedge core_clk_in) begin
      if (init) begin
         go_q <= 1'b0;
      end else if (csr_wr) begin
         go_q <= bus_wdata_in[fast_adc_pkg::CSR_GO_BIT];
      end else if (timer_trig_in && trig_sel == fast_adc_pkg::TRIG_TIMER) begin
         go_q <= 1'b1;
      end else if (pass_end && !scan) begin
         go_q <= 1'b0;
      end
   end

   // done flag: clear only after a read that saw it set; a new set wins
   always_ff @(posedge core_clk_in) begin
      if (init) begin
         flag_q <= 1'b0;
         arm_q <= 1'b0;
      end else begin
         if (pass_end) begin
            flag_q <= 1'b1;
         end else if (csr_wr && arm_q && !bus_wdata_in[fast_adc_pkg::CSR_FLAG_BIT]) begin
            flag_q <= 1'b0;
         end
         if (bus_rd && bus_addr_in == fast_adc_pkg::IDX_CSR && flag_q) begin
            arm_q <= 1'b1;
         end else if (csr_wr) begin
            arm_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (init) begin
         done_irq_out <= 1'b0;
      end else begin
         done_irq_out <= flag_q && irq_en_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer
   always_ff @(posedge core_clk_in) begin
      if (init) begin
         state_q <= ST_IDLE;
         cur_ch_q <= 3'h0;
         cnt_q <= 7'h00;
         conv_start_out <= 1'b0;
      end else begin
         conv_start_out <= 1'b0;
         if (!go_q) begin
            state_q <= ST_IDLE;
         end else begin
            unique case (state_q)
               ST_IDLE: begin
                  // fields written together with go are already in place here
                  state_q <= ST_CONVERT;
                  cur_ch_q <= grp_q ? 3'h0 : ch_sel_q;
                  cnt_q <= cks_q ? fast_adc_pkg::CONV_CYCLES_SLOW : fast_adc_pkg::CONV_CYCLES_FAST;
                  conv_start_out <= 1'b1;
               end
               ST_CONVERT: begin
                  cnt_q <= cnt_q - 7'h01;
                  if (cnt_q == 7'h01) begin
                     state_q <= ST_AWAIT;
                  end
               end
               ST_AWAIT: begin
                  if (drain_fire) begin
                     if (!last_ch) begin
                        cur_ch_q <= cur_ch_q + 3'h1;
                        state_q <= ST_CONVERT;
                        cnt_q <= cks_q ? fast_adc_pkg::CONV_CYCLES_SLOW : fast_adc_pkg::CONV_CYCLES_FAST;
                        conv_start_out <= 1'b1;
                     end else if (!scan) begin
                        state_q <= ST_IDLE;
                     end else if (irq_en_q) begin
                        state_q <= ST_HALTED;
                     end else begin
                        state_q <= ST_IDLE;
                     end
                  end
               end
               ST_HALTED: begin
                  if (!flag_q) begin
                     state_q <= ST_IDLE;
                  end
               end
            endcase
         end
      end
   end

   assign conv_channel_out = cur_ch_q;

   ////////////////////////////////////////////////////////////////////////////
   // result registers and buffer chains
   always_ff @(posedge core_clk_in) begin
      if (init) begin
         for (int i = 0; i < 8; i++) begin
            res_q[i] <= fast_adc_pkg::RESULT_RESET;
         end
      end else if (drain_fire) begin
         res_q[drain_data.channel] <= drain_data.value;
         unique case (buf_sel)
            fast_adc_pkg::BUF_NONE: begin
            end
            fast_adc_pkg::BUF_AB: begin
               if (drain_data.channel == 3'h0) begin
                  res_q[1] <= res_q[0];
               end
            end
            fast_adc_pkg::BUF_AC_BD: begin
               if (drain_data.channel == 3'h0) begin
                  res_q[2] <= res_q[0];
               end
               if (drain_data.channel == 3'h1) begin
                  res_q[3] <= res_q[1];
               end
            end
            fast_adc_pkg::BUF_CHAIN: begin
               if (drain_data.channel == 3'h0) begin
                  res_q[1] <= res_q[0];
                  res_q[2] <= res_q[1];
                  res_q[3] <= res_q[2];
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data, valid the cycle after the read
   always_ff @(posedge core_clk_in) begin
      if (init) begin
         bus_rdata_out <= 16'h0000;
      end else if (bus_rd) begin
         if (is_result(bus_addr_in)) begin
            if (bus_byte_in) begin
               bus_rdata_out <= {8'h00, res_q[bus_addr_in[2:0]][9:2]};
            end else begin
               bus_rdata_out <= {6'h00, res_q[bus_addr_in[2:0]]};
            end
         end else if (bus_addr_in == fast_adc_pkg::IDX_CSR) begin
            bus_rdata_out <= {8'h00, flag_q, irq_en_q, go_q, cks_q, grp_q, ch_sel_q};
         end else if (bus_addr_in == fast_adc_pkg::IDX_CCR) begin
            bus_rdata_out <= {8'h00, 1'b0, ccr_q[6:0]};
         end else begin
            bus_rdata_out <= 16'h0000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // cycles spent converting, counted apart from the down counter so the check does not lean on it
   logic [6:0] conv_len_q;

   always_ff @(posedge core_clk_in) begin
      if (init || state_q != ST_CONVERT) begin
         conv_len_q <= 7'h00;
      end else begin
         conv_len_q <= conv_len_q + 7'h01;
      end
   end

   AST_CCR_INIT: assert property (@(posedge core_clk_in) init |=> ccr_q == 8'h00)
      else $error("control register not cleared");
   AST_RSVD_READ: assert property (@(posedge core_clk_in) disable iff (init)
      bus_rd && bus_addr_in == fast_adc_pkg::IDX_CCR |=> bus_rdata_out[15:7] == 9'h000)
      else $error("reserved bit read back nonzero");
   AST_TRIG_SW: assert property (@(posedge core_clk_in) disable iff (init)
      !go_q && !csr_wr && timer_trig_in && trig_sel != fast_adc_pkg::TRIG_TIMER |=> !go_q)
      else $error("timer started conversion while not selected");
   AST_ABORT: assert property (@(posedge core_clk_in) disable iff (init)
      csr_wr && !bus_wdata_in[fast_adc_pkg::CSR_GO_BIT] |=> ##1 state_q == ST_IDLE)
      else $error("abort did not stop sequencer");
   AST_SINGLE_END: assert property (@(posedge core_clk_in) disable iff (init)
      pass_end && !scan && !csr_wr |=> !go_q && flag_q)
      else $error("single pass end did not clear go and set flag");
   AST_IRQ: assert property (@(posedge core_clk_in) disable iff (init)
      $rose(flag_q) && irq_en_q && !csr_wr |=> done_irq_out)
      else $error("interrupt not raised");
   AST_FLAG_HOLD: assert property (@(posedge core_clk_in) disable iff (init)
      flag_q && !(csr_wr && arm_q) |=> flag_q)
      else $error("done flag cleared without read then write");
   AST_HALT: assert property (@(posedge core_clk_in) disable iff (init)
      state_q == ST_HALTED && flag_q && go_q |=> state_q == ST_HALTED)
      else $error("scan resumed while flag set");
   AST_CONV_TIME: assert property (@(posedge core_clk_in) disable iff (init)
      state_q == ST_CONVERT && go_q && cnt_q == 7'h01 |->
      conv_len_q == (cks_q ? fast_adc_pkg::CONV_CYCLES_SLOW : fast_adc_pkg::CONV_CYCLES_FAST) - 7'h01)
      else $error("conversion time not 40 or 80 states");
   AST_WORD_READ: assert property (@(posedge core_clk_in) disable iff (init)
      bus_rd && is_result(bus_addr_in) && !bus_byte_in |=> bus_rdata_out[15:10] == 6'h00)
      else $error("word read upper bits not zero");
   AST_GROUP_ORDER: assert property (@(posedge core_clk_in) disable iff (init)
      state_q == ST_AWAIT && go_q && drain_fire && !last_ch |=> cur_ch_q == $past(cur_ch_q) + 3'h1)
      else $error("group pass skipped a channel");
   COV_SINGLE: cover property (@(posedge core_clk_in) pass_end && !scan && !grp_q);
   COV_GROUP_SCAN_HALT: cover property (@(posedge core_clk_in) state_q == ST_HALTED && grp_q);
   COV_CHAIN: cover property (@(posedge core_clk_in) drain_fire && buf_sel == fast_adc_pkg::BUF_CHAIN);
   COV_PAIR: cover property (@(posedge core_clk_in) drain_fire && buf_sel == fast_adc_pkg::BUF_AC_BD);
endmodule : fast_adc_mode_control
`default_nettype wire

// file: fast_adc_pkg.sv
// shared constants and types of the fast converter control block
package fast_adc_pkg;
   // register indexes on the 16-bit result/control port
   localparam logic [3:0] IDX_RESULT_A = 4'h0;
   localparam logic [3:0] IDX_RESULT_H = 4'h7;
   localparam logic [3:0] IDX_CSR = 4'h8;
   localparam logic [3:0] IDX_CCR = 4'h9;
   // reset values
   localparam logic [7:0] CCR_RESET = 8'h00;
   localparam logic [9:0] RESULT_RESET = 10'h000;
   // conversion_control fields
   localparam int CCR_RSVD_BIT = 7;
   localparam int CCR_FAST_BIT = 6;
   localparam int CCR_TRIG_HI = 5;
   localparam int CCR_TRIG_LO = 4;
   localparam int CCR_SCAN_BIT = 3;
   localparam int CCR_DUAL_BIT = 2;
   localparam int CCR_BUF_HI = 1;
   localparam int CCR_BUF_LO = 0;
   // control_status_reg fields
   localparam int CSR_FLAG_BIT = 7;
   localparam int CSR_IRQEN_BIT = 6;
   localparam int CSR_GO_BIT = 5;
   localparam int CSR_CKS_BIT = 4;
   localparam int CSR_GRP_BIT = 3;
   localparam int CSR_CH_HI = 2;
   localparam int CSR_CH_LO = 0;
   // trigger source and buffer chain codes
   localparam logic [1:0] TRIG_SOFTWARE = 2'h0;
   localparam logic [1:0] TRIG_TIMER = 2'h1;
   localparam logic [1:0] BUF_NONE = 2'h0;
   localparam logic [1:0] BUF_AB = 2'h1;
   localparam logic [1:0] BUF_AC_BD = 2'h2;
   localparam logic [1:0] BUF_CHAIN = 2'h3;
   // conversion time in states; one state is one clock
   localparam int CLK_PERIOD_NS = 100;
   localparam int CONV_STATES_FAST = 40;
   localparam int CONV_STATES_SLOW = 80;
   localparam logic [6:0] CONV_CYCLES_FAST = 7'(CONV_STATES_FAST);
   localparam logic [6:0] CONV_CYCLES_SLOW = 7'(CONV_STATES_SLOW);
   localparam int FIFO_DEPTH = 4;
   typedef struct packed {
      logic [2:0] channel;
      logic [9:0] value;
   } sample_type;
endpackage : fast_adc_pkg

// file: sample_fifo.sv
// small fifo between the analog front end and the result registers
`timescale 1ns/1ns
`default_nettype none
module sample_fifo #(
   parameter int WIDTH = 13,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // fill side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   // drain side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wptr_q;
   logic [AW-1:0] rptr_q;
   logic [AW:0] count_q;
   logic push;
   logic pop;
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   assign out_data_out = mem_q[rptr_q];
   assign out_valid_out = (count_q != '0);

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_q[wptr_q] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wptr_q <= '0;
         rptr_q <= '0;
         count_q <= '0;
         in_ready_out <= 1'b1;
      end else begin
         if (push) begin
            wptr_q <= (wptr_q == AW'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
         end
         if (pop) begin
            rptr_q <= (rptr_q == AW'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
         end
         // ready is a flop loaded from the next count, so it drops in the cycle the fifo fills and never overruns
         if (push && !pop) begin
            count_q <= count_q + 1'b1;
            in_ready_out <= (count_q != (AW + 1)'(DEPTH - 1));
         end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
            in_ready_out <= 1'b1;
         end
      end
   end
endmodule : sample_fifo
`default_nettype wire

// file: testbench.sv
// self-checking bench of the fast converter control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic clk, rst, stby, sel, wr_en, byte_rd, trig, burst, s_valid, s_ready, start, irq, fast, dual;
   logic [3:0] addr;
   logic [15:0] wdata, rdata, q;
   logic [2:0] chan;
   logic [7:0] delay;
   fast_adc_pkg::sample_type sample;
   int failures = 0;
   int n_checks = 0;
   int n_starts = 0;
   int cnt, s;
   logic [2:0] ch_log [$];
   ////////////////////////////////////////////////////////////////
   fast_adc_mode_control u_dut (.core_clk_in(clk), .sys_rst_in(rst), .standby_in(stby), .bus_sel_in(sel),
      .bus_wr_in(wr_en), .bus_byte_in(byte_rd), .bus_addr_in(addr), .bus_wdata_in(wdata), .bus_rdata_out(rdata),
      .timer_trig_in(trig), .conv_start_out(start), .conv_channel_out(chan), .fast_start_out(fast),
      .dual_sample_out(dual), .sample_valid_in(s_valid), .sample_ready_out(s_ready), .sample_in(sample),
      .done_irq_out(irq));
   fast_adc_front_model u_front (.clk_in(clk), .rst_in(rst), .conv_start_in(start), .channel_in(chan),
      .sample_ready_in(s_ready), .delay_in(delay), .burst_in(burst), .sample_valid_out(s_valid),
      .sample_out(sample));
   initial begin
      clk = 1'b0;
      forever #(fast_adc_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
   end
   always @(posedge clk) begin
      if (start === 1'b1) begin
         n_starts++;
         ch_log.push_back(chan);
      end
   end
   ////////////////////////////////////////////////////////////////
   function automatic logic [9:0] mk(input logic [2:0] c, input logic [5:0] n);
      return 10'h200 + {1'b0, n, c};
   endfunction : mk
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: word %h expected %h", $time, got, exp);
      end
   endtask : chk_word
   task automatic chk_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: bit %b expected %b", $time, got, exp);
      end
   endtask : chk_bit
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge clk);
      sel = 1'b1;
      wr_en = 1'b1;
      addr = a;
      wdata = {8'h00, d};
      @(negedge clk);
      sel = 1'b0;
      wr_en = 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic b, output logic [15:0] v);
      @(negedge clk);
      sel = 1'b1;
      byte_rd = b;
      addr = a;
      @(negedge clk);
      sel = 1'b0;
      v = rdata;
   endtask : rd
   task automatic rdchk(input logic [3:0] a, input logic b, input logic [15:0] e);
      logic [15:0] v;
      rd(a, b, v);
      chk_word(v, e);
   endtask : rdchk
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask : idle
   task automatic wait_start(input int s0);
      for (int i = 0; i < 100 && n_starts == s0; i++) @(negedge clk);
      chk_bit(n_starts > s0, 1'b1);
   endtask : wait_start
   task automatic wait_irq;
      for (int i = 0; i < 300 && irq !== 1'b1; i++) @(negedge clk);
      chk_bit(irq, 1'b1);
   endtask : wait_irq
   task automatic poll_flag;
      for (int i = 0; i < 200; i++) begin
         rd(4'h8, 1'b0, q);
         if (q[7] === 1'b1) break;
      end
   endtask : poll_flag
   task automatic pulse;
      trig = 1'b1;
      @(negedge clk);
      trig = 1'b0;
   endtask : pulse
   task automatic results;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results
   // generous bound: the tests take under 3000 cycles
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      $display("unexpected at %0t: watchdog expired", $time);
      results();
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      {rst, stby, sel, wr_en, byte_rd, trig, burst} = '1;
      {stby, sel, wr_en, byte_rd, trig, burst} = '0;
      addr = 4'h0;
      wdata = 16'h0000;
      delay = 8'h2d;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      rdchk(4'h9, 1'b0, 16'h0000);
      rdchk(4'h8, 1'b0, 16'h0000);
      wr(4'h0, 8'hff);
      rdchk(4'h0, 1'b0, 16'h0000);
      rdchk(4'ha, 1'b0, 16'h0000);
      wr(4'h9, 8'hff);
      rdchk(4'h9, 1'b0, 16'h007f);
      chk_bit(fast, 1'b1);
      chk_bit(dual, 1'b1);
      stby = 1'b1;
      idle(2);
      stby = 1'b0;
      rdchk(4'h9, 1'b0, 16'h0000);
      chk_bit(fast, 1'b0);
      $display("test registers done");
      s = n_starts;
      wr(4'h8, 8'h61);
      wait_start(s);
      chk_bit(chan === 3'h1, 1'b1);
      rdchk(4'h8, 1'b0, 16'h0061);
      wait_irq();
      rdchk(4'h1, 1'b0, 16'(mk(3'h1, 6'h00)));
      rdchk(4'h1, 1'b1, 16'(mk(3'h1, 6'h00) >> 2));
      wr(4'h8, 8'h40);
      rdchk(4'h8, 1'b0, 16'h00c0);
      wr(4'h8, 8'h40);
      rdchk(4'h8, 1'b0, 16'h0040);
      chk_bit(irq, 1'b0);
      $display("test select single done");
      wr(4'h9, 8'h09);
      delay = 8'h5a;
      s = n_starts;
      wr(4'h8, 8'h70);
      wait_start(s);
      cnt = 0;
      while (irq !== 1'b1 && cnt < 300) begin
         @(negedge clk);
         cnt++;
      end
      chk_bit(cnt >= 80 && cnt < 300, 1'b1);
      s = n_starts;
      idle(150);
      chk_word(16'(n_starts), 16'(s));
      rdchk(4'h8, 1'b0, 16'h00f0);
      rdchk(4'h0, 1'b0, 16'(mk(3'h0, 6'h01)));
      wr(4'h8, 8'h70);
      wait_start(s);
      wait_irq();
      rdchk(4'h0, 1'b0, 16'(mk(3'h0, 6'h02)));
      rdchk(4'h1, 1'b0, 16'(mk(3'h0, 6'h01)));
      rdchk(4'h8, 1'b0, 16'h00f0);
      wr(4'h8, 8'h00);
      s = n_starts;
      idle(150);
      chk_word(16'(n_starts), 16'(s));
      rdchk(4'h8, 1'b0, 16'h0000);
      $display("test select scan done");
      wr(4'h9, 8'h00);
      delay = 8'h2d;
      s = ch_log.size();
      wr(4'h8, 8'h2a);
      poll_flag();
      rdchk(4'h8, 1'b0, 16'h008a);
      chk_word(16'(ch_log.size() - s), 16'h0003);
      for (int c = 0; c < 3; c++) begin
         chk_word(16'(ch_log[s + c]), 16'(c));
         rdchk(4'(c), 1'b0, 16'(mk(3'(c), 6'(3 + c))));
      end
      $display("test group single done");
      wr(4'h8, 8'h00);
      s = n_starts;
      pulse();
      idle(60);
      chk_word(16'(n_starts), 16'(s));
      wr(4'h9, 8'h10);
      pulse();
      wait_start(s);
      poll_flag();
      rdchk(4'h0, 1'b0, 16'(mk(3'h0, 6'h06)));
      $display("test timer trigger done");
      wr(4'h9, 8'h0a);
      s = ch_log.size();
      wr(4'h8, 8'h69);
      wait_irq();
      for (int c = 0; c < 2; c++) begin
         chk_word(16'(ch_log[s + c]), 16'(c));
      end
      rdchk(4'h0, 1'b0, 16'(mk(3'h0, 6'h07)));
      rdchk(4'h1, 1'b0, 16'(mk(3'h1, 6'h08)));
      rdchk(4'h2, 1'b0, 16'(mk(3'h0, 6'h06)));
      rdchk(4'h3, 1'b0, 16'(mk(3'h1, 6'h04)));
      rdchk(4'h8, 1'b0, 16'h00e9);
      s = n_starts;
      idle(150);
      chk_word(16'(n_starts), 16'(s));
      wr(4'h8, 8'h69);
      wait_start(s);
      wr(4'h8, 8'h00);
      // let the sample of the aborted conversion drain before the fifo test
      idle(60);
      $display("test group scan done");
      wr(4'h9, 8'h00);
      idle(1);
      // result reads every cycle stall the drain, so the fifo fills
      burst = 1'b1;
      sel = 1'b1;
      addr = 4'h0;
      idle(12);
      chk_bit(s_ready, 1'b0);
      sel = 1'b0;
      burst = 1'b0;
      idle(12);
      chk_bit(s_ready, 1'b1);
      $display("test fifo fill done");
      results();
   end
endmodule : testbench
`default_nettype wire
